// file: logic/vid_ramp_consts.vh
`ifndef VID_RAMP_CONSTS_VH
`define VID_RAMP_CONSTS_VH

// register offsets
`define SPECIAL_CTRL2_ADDR 8'hbd
`define INPUT_THRESHOLD_SELECT_ADDR 8'hbe
`define HOT_RAMP_INTERVAL_ADDR 8'hbf

// reset values
`define SPECIAL_CTRL2_RESET 8'h00
`define INPUT_THRESHOLD_SELECT_RESET 8'h00
`define HOT_RAMP_INTERVAL_RESET 8'h00

// special control 2 fields
`define SMART_TACH_LSB 0
`define SMART_TACH_MSB 3
`define VID_SEL_LSB 6
`define VID_SEL_MSB 7

// input_threshold_select fields
`define CPU_A_VID_LVL_BIT 0
`define CPU_B_VID_LVL_BIT 1
`define GEN_IN_8_LVL_BIT 2
`define GEN_IN_9_LVL_BIT 3
`define GP_PIN_LVL_LSB 4
`define GP_PIN_LVL_MSB 7

// hot_ramp_interval fields
`define REG_RAMP_LSB 0
`define REG_RAMP_MSB 3
`define PROC_RAMP_LSB 4
`define PROC_RAMP_MSB 7

// vid interpretation select codes
`define VID_SEL_SIX_BIT 2'h0
`define VID_SEL_SEVEN_BIT 2'h1
`define VID_SEL_LOW_SEVEN 2'h2
`define VID_SEL_HIGH_SEVEN 2'h3

// voltages in units of 10 uV
`define VID_TOP_10UV 18'h27100
`define VID_FINE_STEP_10UV 18'h00271
`define VID_COARSE_STEP_10UV 18'h004e2
`define VID_MIN_SIX_10UV 18'h14726
`define VID_MIN_SEVEN_10UV 18'h144b5
`define VID_MIN_HIGH_10UV 18'h00ea6

// ramp timing
`define CLK_SYS_MHZ 200
`define RAMP_UNIT_MS 50
`define RAMP_UNIT_CYCLES (`RAMP_UNIT_MS * 1000 * `CLK_SYS_MHZ)
`define DUTY_FULL 8'hff

`endif

// file: logic/hot_ramp_stepper.v
`timescale 1ns/1ps
`include "vid_ramp_consts.vh"

module hot_ramp_stepper #(
    parameter [7:0] STEP = 8'h10
) (
    // clock and reset
    input wire clk_sys,
    input wire rst,
    // control
    input wire hot,
    input wire unit_tick,
    input wire [3:0] interval,
    input wire [7:0] start_duty,
    // result
    output reg [7:0] ramp_duty_q,
    output reg ramp_active_q
);

localparam IDLE = 2'h0;
localparam UP = 2'h1;
localparam DOWN = 2'h2;

reg [1:0] state_q;
reg [3:0] tick_cnt_q;
wire step_due;
wire [8:0] up_sum;

assign step_due = unit_tick && (tick_cnt_q + 4'h1 >= interval);
assign up_sum = {1'b0, ramp_duty_q} + {1'b0, STEP};

always @(posedge clk_sys) begin
    if (rst) begin
        state_q <= IDLE;
        tick_cnt_q <= 4'h0;
        ramp_duty_q <= 8'h00;
        ramp_active_q <= 1'b0;
    end else begin
        if (unit_tick) begin
            tick_cnt_q <= step_due ? 4'h0 : tick_cnt_q + 4'h1;
        end
        case (state_q)
            IDLE: begin
                if (hot) begin
                    state_q <= UP;
                    ramp_active_q <= 1'b1;
                    tick_cnt_q <= 4'h0;
                    // zero interval skips the ramp entirely
                    ramp_duty_q <= (interval == 4'h0) ? `DUTY_FULL
                                                      : start_duty;
                end
            end
            UP: begin
                if (interval == 4'h0) begin
                    ramp_duty_q <= `DUTY_FULL;
                end else if (step_due) begin
                    ramp_duty_q <= up_sum[8] ? `DUTY_FULL
                                             : up_sum[7:0];
                end
                if (!hot) begin
                    state_q <= DOWN;
                    tick_cnt_q <= 4'h0;
                end
            end
            DOWN: begin
                if (hot) begin
                    state_q <= UP;
                end else if (interval == 4'h0 ||
                             ramp_duty_q <= start_duty ||
                             ramp_duty_q < STEP) begin
                    state_q <= IDLE;
                    ramp_active_q <= 1'b0;
                    ramp_duty_q <= 8'h00;
                end else if (step_due) begin
                    ramp_duty_q <= ramp_duty_q - STEP;
                end
            end
            default: begin
                state_q <= IDLE;
            end
        endcase
    end
end

endmodule

// file: logic/vid_decode_and_hot_pwm_ramp.v
`timescale 1ns/1ps
`include "vid_ramp_consts.vh"

module vid_decode_and_hot_pwm_ramp #(
    parameter RAMP_UNIT_CYCLES = `RAMP_UNIT_CYCLES,
    parameter [7:0] RAMP_STEP = 8'h10
) (
    // clock and reset
    input wire clk_sys,
    input wire rst,
    // register port
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    input wire reg_rd,
    output reg [7:0] reg_rdata_q,
    // voltage id inputs
    input wire [7:0] cpu_a_voltage_id_inputs,
    input wire [7:0] cpu_b_voltage_id_inputs,
    // decoded voltage ids
    output reg [6:0] cpu_a_vid_value_q,
    output reg [6:0] cpu_b_vid_value_q,
    output reg [17:0] cpu_a_vid_10uv_q,
    output reg [17:0] cpu_b_vid_10uv_q,
    // input threshold selects to pad cells
    output reg cpu_a_vid_low_threshold_q,
    output reg cpu_b_vid_low_threshold_q,
    output reg gen_input_8_low_threshold_q,
    output reg gen_input_9_low_threshold_q,
    output reg [3:0] gp_pin_low_threshold_q,
    // smart tach enables
    output wire [3:0] smart_tach_enable,
    // hot inputs
    input wire [1:0] processor_hot_input,
    input wire [1:0] regulator_hot_input,
    // pwm duty
    input wire [7:0] pwm_1_normal_duty,
    input wire [7:0] pwm_2_normal_duty,
    output reg [7:0] pwm_1_duty_q,
    output reg [7:0] pwm_2_duty_q,
    output wire processor_ramp_active,
    output wire regulator_ramp_active
);

reg [7:0] special_ctrl2_q;
reg [7:0] input_threshold_select_q;
reg [7:0] hot_ramp_interval_q;
reg [31:0] unit_cnt_q;
reg unit_tick_q;
wire [1:0] vid_interpretation_select;
wire [3:0] regulator_hot_ramp_interval;
wire [3:0] processor_hot_ramp_interval;
wire [7:0] proc_duty;
wire [7:0] reg_duty;
wire [7:0] start_duty;
wire [7:0] hot_duty;

////////////////////////////////////////////////////////////////////////////
// vid decode

// returns the effective vid code for the selected interpretation
function [6:0] vid_code;
    input [1:0] sel;
    input [7:0] vid;
    begin
        if (sel == `VID_SEL_SIX_BIT) begin
            vid_code = {1'b0, vid[5:0]};
        end else if (sel == `VID_SEL_SEVEN_BIT) begin
            vid_code = vid[6:0];
        end else if (sel == `VID_SEL_LOW_SEVEN) begin
            vid_code = vid[6:0];
        end else begin
            vid_code = vid[7:1];
        end
    end
endfunction

// voltage in 10 uV units, clamped at the bottom of each range
function [17:0] vid_volts;
    input [1:0] sel;
    input [6:0] code;
    reg [17:0] drop;
    reg [17:0] floor_v;
    reg [17:0] v;
    begin
        drop = 18'h00000;
        floor_v = `VID_MIN_SEVEN_10UV;
        v = 18'h00000;
        if (sel == `VID_SEL_SIX_BIT) begin
            drop = code * `VID_COARSE_STEP_10UV;
            floor_v = `VID_MIN_SIX_10UV;
        end else if (sel == `VID_SEL_HIGH_SEVEN) begin
            drop = code * `VID_COARSE_STEP_10UV;
            floor_v = `VID_MIN_HIGH_10UV;
        end else begin
            drop = code * `VID_FINE_STEP_10UV;
        end
        v = `VID_TOP_10UV - drop;
        if (drop > `VID_TOP_10UV || v < floor_v) begin
            vid_volts = floor_v;
        end else begin
            vid_volts = v;
        end
    end
endfunction

assign vid_interpretation_select =
    special_ctrl2_q[`VID_SEL_MSB:`VID_SEL_LSB];
assign smart_tach_enable =
    special_ctrl2_q[`SMART_TACH_MSB:`SMART_TACH_LSB];

always @(posedge clk_sys) begin
    if (rst) begin
        cpu_a_vid_value_q <= 7'h00;
        cpu_b_vid_value_q <= 7'h00;
        cpu_a_vid_10uv_q <= 18'h00000;
        cpu_b_vid_10uv_q <= 18'h00000;
    end else begin
        cpu_a_vid_value_q <= vid_code(vid_interpretation_select,
                                      cpu_a_voltage_id_inputs);
        cpu_b_vid_value_q <= vid_code(vid_interpretation_select,
                                      cpu_b_voltage_id_inputs);
        cpu_a_vid_10uv_q <= vid_volts(vid_interpretation_select,
            vid_code(vid_interpretation_select, cpu_a_voltage_id_inputs));
        cpu_b_vid_10uv_q <= vid_volts(vid_interpretation_select,
            vid_code(vid_interpretation_select, cpu_b_voltage_id_inputs));
    end
end

////////////////////////////////////////////////////////////////////////////
// register port

always @(posedge clk_sys) begin
    if (rst) begin
        special_ctrl2_q <= `SPECIAL_CTRL2_RESET;
        input_threshold_select_q <= `INPUT_THRESHOLD_SELECT_RESET;
        hot_ramp_interval_q <= `HOT_RAMP_INTERVAL_RESET;
        reg_rdata_q <= 8'h00;
    end else begin
        if (reg_wr) begin
            if (reg_addr == `SPECIAL_CTRL2_ADDR) begin
                special_ctrl2_q <= reg_wdata;
            end else if (reg_addr == `INPUT_THRESHOLD_SELECT_ADDR) begin
                input_threshold_select_q <= reg_wdata;
            end else if (reg_addr == `HOT_RAMP_INTERVAL_ADDR) begin
                hot_ramp_interval_q <= reg_wdata;
            end
        end
        if (reg_rd) begin
            if (reg_addr == `SPECIAL_CTRL2_ADDR) begin
                reg_rdata_q <= special_ctrl2_q;
            end else if (reg_addr == `INPUT_THRESHOLD_SELECT_ADDR) begin
                reg_rdata_q <= input_threshold_select_q;
            end else if (reg_addr == `HOT_RAMP_INTERVAL_ADDR) begin
                reg_rdata_q <= hot_ramp_interval_q;
            end else begin
                reg_rdata_q <= 8'h00;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// input thresholds

always @(posedge clk_sys) begin
    if (rst) begin
        cpu_a_vid_low_threshold_q <= 1'b0;
        cpu_b_vid_low_threshold_q <= 1'b0;
        gen_input_8_low_threshold_q <= 1'b0;
        gen_input_9_low_threshold_q <= 1'b0;
        gp_pin_low_threshold_q <= 4'h0;
    end else begin
        cpu_a_vid_low_threshold_q <=
            input_threshold_select_q[`CPU_A_VID_LVL_BIT];
        cpu_b_vid_low_threshold_q <=
            input_threshold_select_q[`CPU_B_VID_LVL_BIT];
        gen_input_8_low_threshold_q <=
            input_threshold_select_q[`GEN_IN_8_LVL_BIT] &&
            vid_interpretation_select == `VID_SEL_SIX_BIT;
        gen_input_9_low_threshold_q <=
            input_threshold_select_q[`GEN_IN_9_LVL_BIT] &&
            vid_interpretation_select == `VID_SEL_SIX_BIT;
        gp_pin_low_threshold_q <=
            input_threshold_select_q[`GP_PIN_LVL_MSB:`GP_PIN_LVL_LSB];
    end
end

////////////////////////////////////////////////////////////////////////////
// hot ramp timing

assign regulator_hot_ramp_interval =
    hot_ramp_interval_q[`REG_RAMP_MSB:`REG_RAMP_LSB];
assign processor_hot_ramp_interval =
    hot_ramp_interval_q[`PROC_RAMP_MSB:`PROC_RAMP_LSB];

// one pulse per 50 ms unit; stepper waits code units per step
always @(posedge clk_sys) begin
    if (rst) begin
        unit_cnt_q <= 32'h00000000;
        unit_tick_q <= 1'b0;
    end else if (unit_cnt_q >= RAMP_UNIT_CYCLES - 1) begin
        unit_cnt_q <= 32'h00000000;
        unit_tick_q <= 1'b1;
    end else begin
        unit_cnt_q <= unit_cnt_q + 32'h00000001;
        unit_tick_q <= 1'b0;
    end
end

assign start_duty = (pwm_1_normal_duty > pwm_2_normal_duty) ?
                    pwm_1_normal_duty : pwm_2_normal_duty;

hot_ramp_stepper #(
    .STEP(RAMP_STEP)
) proc_ramp (
    .clk_sys(clk_sys),
    .rst(rst),
    .hot(|processor_hot_input),
    .unit_tick(unit_tick_q),
    .interval(processor_hot_ramp_interval),
    .start_duty(start_duty),
    .ramp_duty_q(proc_duty),
    .ramp_active_q(processor_ramp_active)
);

hot_ramp_stepper #(
    .STEP(RAMP_STEP)
) reg_ramp (
    .clk_sys(clk_sys),
    .rst(rst),
    .hot(|regulator_hot_input),
    .unit_tick(unit_tick_q),
    .interval(regulator_hot_ramp_interval),
    .start_duty(start_duty),
    .ramp_duty_q(reg_duty),
    .ramp_active_q(regulator_ramp_active)
);

assign hot_duty = (proc_duty > reg_duty) ? proc_duty : reg_duty;

// ramp only ever raises duty above normal control
always @(posedge clk_sys) begin
    if (rst) begin
        pwm_1_duty_q <= 8'h00;
        pwm_2_duty_q <= 8'h00;
    end else begin
        pwm_1_duty_q <= (hot_duty > pwm_1_normal_duty) ? hot_duty
                                                       : pwm_1_normal_duty;
        pwm_2_duty_q <= (hot_duty > pwm_2_normal_duty) ? hot_duty
                                                       : pwm_2_normal_duty;
    end
end

endmodule

// file: verif/vid_hot_source.sv
`timescale 1ns/1ps
module vid_hot_source (
    // clock and reset
    input wire clk_sys,
    input wire rst,
    // requested pin levels
    input wire [7:0] vid_a_set,
    input wire [7:0] vid_b_set,
    input wire [1:0] proc_hot_set,
    input wire [1:0] reg_hot_set,
    // pins toward the monitor
    output reg [7:0] vid_a_q,
    output reg [7:0] vid_b_q,
    output reg [1:0] proc_hot_q,
    output reg [1:0] reg_hot_q
);
    // pins move only just after an edge; hot lines low through reset
    always @(posedge clk_sys) begin
        if (rst) begin
            proc_hot_q <= 2'h0;
            reg_hot_q <= 2'h0;
        end else begin
            proc_hot_q <= proc_hot_set;
            reg_hot_q <= reg_hot_set;
        end
        vid_a_q <= vid_a_set;
        vid_b_q <= vid_b_set;
    end
endmodule

// file: verif/vid_ramp_asserts.sv
`timescale 1ns/1ps
`include "vid_ramp_consts.vh"
module vid_ramp_asserts (
    // clock and reset
    input wire clk_sys,
    input wire rst,
    // register port
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    input wire reg_rd,
    input wire [7:0] reg_rdata_q,
    // vid and thresholds
    input wire [7:0] cpu_a_voltage_id_inputs,
    input wire [6:0] cpu_a_vid_value_q,
    input wire [17:0] cpu_a_vid_10uv_q,
    input wire cpu_a_vid_low_threshold_q,
    input wire [3:0] gp_pin_low_threshold_q,
    // ramp
    input wire [1:0] processor_hot_input,
    input wire [7:0] pwm_1_normal_duty,
    input wire [7:0] pwm_1_duty_q,
    input wire processor_ramp_active
);
    reg [1:0] sel_q;
    reg [7:0] thr_q;
    reg [3:0] pcode_q;
    wire [7:0] vid = cpu_a_voltage_id_inputs;
    wire coarse = sel_q == 2'h0 || sel_q == 2'h3;
    wire [6:0] code_w = sel_q == 2'h0 ? {1'b0, vid[5:0]} :
        sel_q == 2'h3 ? vid[7:1] : vid[6:0];
    wire [17:0] step_w = coarse ? `VID_COARSE_STEP_10UV : `VID_FINE_STEP_10UV;
    wire [17:0] floor_w = sel_q == 2'h0 ? `VID_MIN_SIX_10UV :
        sel_q == 2'h3 ? `VID_MIN_HIGH_10UV : `VID_MIN_SEVEN_10UV;
    wire [17:0] raw_w = `VID_TOP_10UV - {11'h0, code_w} * step_w;
    wire [17:0] volt_w = raw_w < floor_w ? floor_w : raw_w;
    // shadow of the fields the checks depend on
    always @(posedge clk_sys) begin
        if (rst) begin
            sel_q <= 2'h0;
            thr_q <= 8'h00;
            pcode_q <= 4'h0;
        end else if (reg_wr && reg_addr == 8'hbd) begin
            sel_q <= reg_wdata[7:6];
        end else if (reg_wr && reg_addr == 8'hbe) begin
            thr_q <= reg_wdata;
        end else if (reg_wr && reg_addr == 8'hbf) begin
            pcode_q <= reg_wdata[7:4];
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence wr_ramp_s;
        reg_wr && reg_addr == 8'hbf;
    endsequence
    sequence rd_ramp_s;
        reg_rd && !reg_wr && reg_addr == 8'hbf;
    endsequence
    sequence calm_s;
        !reg_wr && $stable(vid) && !$past(rst);
    endsequence
    rd_after_wr_a: assert property (wr_ramp_s ##1 !reg_wr
        ##1 rd_ramp_s |=> reg_rdata_q == $past(reg_wdata, 3))
        else $error("readback wrong");
    unmapped_rd_a: assert property (reg_rd && (reg_addr < 8'hbd ||
        reg_addr > 8'hbf) |=> reg_rdata_q == 8'h00) else $error("unmapped");
    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata_q))
        else $error("read data moved");
    low_level_a: assert property (reg_wr && reg_addr == 8'hbe
        ##1 !reg_wr |=> {gp_pin_low_threshold_q, cpu_a_vid_low_threshold_q} ==
        {thr_q[7:4], thr_q[0]}) else $error("threshold select wrong");
    vid_code_a: assert property (calm_s ##1 calm_s
        |-> cpu_a_vid_value_q == code_w) else $error("vid code wrong");
    vid_volt_a: assert property (calm_s ##1 calm_s
        |-> cpu_a_vid_10uv_q == volt_w) else $error("vid voltage wrong");
    ramp_start_a: assert property ((|processor_hot_input) &&
        !processor_ramp_active |=> processor_ramp_active)
        else $error("no ramp");
    zero_interval_a: assert property (((|processor_hot_input) &&
        pcode_q == 4'h0) [*4] |-> pwm_1_duty_q == `DUTY_FULL)
        else $error("zero interval not full duty");
    duty_floor_a: assert property (!rst ##1 !rst
        |-> pwm_1_duty_q >= $past(pwm_1_normal_duty)) else $error("duty low");
endmodule
bind vid_decode_and_hot_pwm_ramp vid_ramp_asserts chk_u (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .cpu_a_voltage_id_inputs(cpu_a_voltage_id_inputs),
    .cpu_a_vid_value_q(cpu_a_vid_value_q),
    .cpu_a_vid_10uv_q(cpu_a_vid_10uv_q),
    .cpu_a_vid_low_threshold_q(cpu_a_vid_low_threshold_q),
    .gp_pin_low_threshold_q(gp_pin_low_threshold_q),
    .processor_hot_input(processor_hot_input),
    .pwm_1_normal_duty(pwm_1_normal_duty), .pwm_1_duty_q(pwm_1_duty_q),
    .processor_ramp_active(processor_ramp_active)
);

// file: verif/tb.sv
`timescale 1ns/1ps
module tb;
    reg clk_sys;
    reg rst;
    reg [7:0] reg_addr;
    reg reg_wr;
    reg [7:0] reg_wdata;
    reg reg_rd;
    reg [7:0] vid_a_set;
    reg [7:0] vid_b_set;
    reg [1:0] proc_hot_set;
    reg [1:0] reg_hot_set;
    reg [7:0] norm_1;
    reg [7:0] norm_2;
    wire [7:0] reg_rdata_q;
    wire [7:0] vid_a;
    wire [7:0] vid_b;
    wire [1:0] proc_hot;
    wire [1:0] reg_hot;
    wire [6:0] vid_b_code;
    wire [7:0] lvl;
    wire [7:0] duty_1;
    wire [7:0] duty_2;
    wire [3:0] tach;
    wire [17:0] vid_b_volts;
    wire proc_active;
    wire reg_active;
    integer mismatches = 0;
    integer num_checks = 0;
    integer cycles = 0;
    integer seed = 67;
    reg rd_d = 1'b0;
    reg [7:0] exp_q[$];
    vid_hot_source src_u (
        .clk_sys(clk_sys), .rst(rst), .vid_a_set(vid_a_set),
        .vid_b_set(vid_b_set), .proc_hot_set(proc_hot_set),
        .reg_hot_set(reg_hot_set), .vid_a_q(vid_a), .vid_b_q(vid_b),
        .proc_hot_q(proc_hot), .reg_hot_q(reg_hot)
    );
    vid_decode_and_hot_pwm_ramp #(.RAMP_UNIT_CYCLES(4)) dut_u (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .cpu_a_voltage_id_inputs(vid_a), .cpu_b_voltage_id_inputs(vid_b),
        .cpu_a_vid_value_q(), .cpu_b_vid_value_q(vid_b_code),
        .cpu_a_vid_10uv_q(), .cpu_b_vid_10uv_q(vid_b_volts),
        .cpu_a_vid_low_threshold_q(lvl[0]), .cpu_b_vid_low_threshold_q(lvl[1]),
        .gen_input_8_low_threshold_q(lvl[2]),
        .gen_input_9_low_threshold_q(lvl[3]),
        .gp_pin_low_threshold_q(lvl[7:4]), .smart_tach_enable(tach),
        .processor_hot_input(proc_hot), .regulator_hot_input(reg_hot),
        .pwm_1_normal_duty(norm_1), .pwm_2_normal_duty(norm_2),
        .pwm_1_duty_q(duty_1), .pwm_2_duty_q(duty_2),
        .processor_ramp_active(proc_active),
        .regulator_ramp_active(reg_active)
    );
    task chk(input [17:0] got, input [17:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task wrap_up;
        begin
            if (mismatches == 0 && num_checks > 0) begin
                $display("Run complete: PASS");
            end else begin
                $display("Run complete: FAIL");
            end
            $finish;
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge clk_sys);
            reg_wr <= 1'b1;
            reg_addr <= a;
            reg_wdata <= d;
            @(posedge clk_sys);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [7:0] e);
        begin
            exp_q.push_back(e);
            @(posedge clk_sys);
            reg_rd <= 1'b1;
            reg_addr <= a;
            @(posedge clk_sys);
            reg_rd <= 1'b0;
        end
    endtask
    // edges until duty_1 leaves target, or reaches it when moved is set, bounded
    task wait_duty(input [7:0] target, input moved, output integer n);
        begin
            n = 0;
            while (((duty_1 === target) ^ moved) && n < 999) begin
                @(posedge clk_sys);
                n = n + 1;
            end
        end
    endtask
    task ramp_gap(input p, input [3:0] code);
        integer n;
        begin
            wr(8'hbf, p ? {code, 4'h0} : {4'h0, code});
            rd(8'hbf, p ? {code, 4'h0} : {4'h0, code});
            proc_hot_set <= {1'b0, p};
            reg_hot_set <= {~p, 1'b0};
            repeat (3) wait_duty(duty_1, 1'b0, n);
            chk(n[7:0], {2'h0, code, 2'h0});
            wait_duty(8'hff, 1'b1, n);
            chk(duty_1, 8'hff);
            chk(duty_2, 8'hff);
            proc_hot_set <= 2'h0;
            reg_hot_set <= 2'h0;
            repeat (4) @(posedge clk_sys);
            n = 0;
            while ((proc_active | reg_active) !== 1'b0 && n < 999) begin
                @(posedge clk_sys);
                n = n + 1;
            end
            repeat (2) @(posedge clk_sys);
            chk(duty_1, norm_1);
            chk(duty_2, norm_2);
        end
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles = cycles + 1;
        rd_d <= reg_rd;
        if (rd_d) begin
            chk(reg_rdata_q, exp_q.pop_front());
        end
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            wrap_up;
        end
    end
    initial begin : main
        integer i;
        integer n;
        reg [7:0] thr;
        reg [7:0] v;
        reg [7:0] e;
        integer ev;
        integer fl;
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
        vid_a_set = 8'h00;
        vid_b_set = 8'h00;
        proc_hot_set = 2'h0;
        reg_hot_set = 2'h0;
        norm_1 = $random(seed) & 8'h3f;
        norm_2 = $random(seed) & 8'h3f;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        rd(8'hbd, 8'h00);
        rd(8'hbe, 8'h00);
        rd(8'hbf, 8'h00);
        rd(8'hc0, 8'h00);
        thr = $random(seed);
        wr(8'hbe, thr);
        rd(8'hbe, thr);
        chk(lvl & 8'hf3, thr & 8'hf3);
        for (i = 0; i < 4; i = i + 1) begin
            v = $random(seed);
            // smart tach bits left clear throughout
            wr(8'hbd, {i[1:0], 6'h00});
            vid_a_set <= $random(seed);
            vid_b_set <= v;
            repeat (4) @(posedge clk_sys);
            rd(8'hbd, {i[1:0], 6'h00});
            e = i == 0 ? {2'h0, v[5:0]} :
                i == 3 ? {1'b0, v[7:1]} : {1'b0, v[6:0]};
            chk({1'b0, vid_b_code}, e);
            // volts in 10 uV: 1.6 V less code steps, clamped at range floor
            ev = 160000 - e * ((i == 0 || i == 3) ? 1250 : 625);
            fl = i == 0 ? 83750 : i == 3 ? 3750 : 83125;
            if (ev < fl) begin
                ev = fl;
            end
            chk(vid_b_volts, ev[17:0]);
            chk({4'h0, tach}, 8'h00);
            e = i == 0 ? thr & 8'h0c : 8'h00;
            chk(lvl & 8'h0c, e);
        end
        wr(8'hbf, 8'h00);
        proc_hot_set <= 2'h2;
        repeat (5) @(posedge clk_sys);
        chk(duty_1, 8'hff);
        proc_hot_set <= 2'h0;
        repeat (20) @(posedge clk_sys);
        ramp_gap(1'b1, 4'h3);
        ramp_gap(1'b0, 4'h2);
        repeat (3) @(posedge clk_sys);
        wrap_up;
    end
endmodule
